// [verilog/nested_interrupt_priority.sv]
// nested interrupt priority logic: level bits, per-vector levels, arbitration, wake
//
// Local design decisions: the address map and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module nested_interrupt_priority (
  input  wire logic                    clk,
  input  wire logic                    rst_b,
  input  wire nest_prio_pkg::apb_req_t apb_req,
  output nest_prio_pkg::apb_rsp_t      apb_rsp,
  input  wire nest_prio_pkg::cpu_op_t  cpu_op,
  input  wire logic [7:0]              stacked_cc,
  input  wire logic                    cpu_accept,
  input  wire logic [13:0]             irq_req,
  input  wire logic                    ext_line_zero_req,
  input  wire logic                    auto_wake_from_halt_req,
  input  wire logic                    ext_line_one_req,
  input  wire logic                    aux_voltage_detector_req,
  input  wire logic                    can_status_change,
  input  wire logic [13:0]             irq_enable,
  input  wire logic                    active_halt_sel,
  output nest_prio_pkg::svc_t          svc,
  output logic [7:0]                   cpu_condition_priority,
  output logic                         branch_if_masked,
  output logic                         branch_if_unmasked,
  output logic                         halted,
  output logic                         wake
);
  import nest_prio_pkg::*;

  logic [1:0]  cc_q;
  logic [1:0]  prio_q [NUM_VEC];
  logic [13:0] pend_q;
  logic [13:0] pend_clr;
  logic [13:0] pend_set;
  logic        no_wake_q;
  logic        restrict_q;
  svc_t        svc_q;
  logic [31:0] prdata_q;
  logic        wr_en;
  logic        rd_en;
  logic        addr_ok;
  logic [7:0]  prio_reg [4];

  function automatic logic [2:0] rank_of(input logic [1:0] p);
    unique case (p)
      LVL0:    rank_of = 3'h0;
      LVL1:    rank_of = 3'h1;
      LVL2:    rank_of = 3'h2;
      default: rank_of = 3'h3;
    endcase
  endfunction : rank_of

  // register bus
  assign wr_en = apb_req.psel && apb_req.penable && apb_req.pwrite;
  assign rd_en = apb_req.psel && !apb_req.penable && !apb_req.pwrite;
  always_comb begin
    unique case (apb_req.paddr)
      OFF_PRIO0, OFF_PRIO1, OFF_PRIO2, OFF_PRIO3, OFF_CC, OFF_PENDING: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end

  // pair n sits at bits 2(n%4)+1:2(n%4) of register n/4
  genvar gi;
  generate
    for (gi = 0; gi < NUM_VEC; gi++) begin : g_pair
      localparam logic [7:0] REG_OFF = 8'((gi / 4) * 4);
      localparam int unsigned BIT_LO = (gi % 4) * 2;
      logic [1:0] wr_val;
      assign wr_val = apb_req.pwdata[BIT_LO+1:BIT_LO];
      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          prio_q[gi] <= PRIO_RESET[1:0];
        end else if (wr_en && apb_req.paddr == REG_OFF && wr_val != LVL0) begin
          prio_q[gi] <= wr_val;
        end
      end
    end
  endgenerate

  always_comb begin
    for (int r = 0; r < 4; r++) begin
      prio_reg[r] = 8'h00;
    end
    for (int v = 0; v < NUM_VEC; v++) begin
      prio_reg[v / 4][(v % 4) * 2 +: 2] = prio_q[v];
    end
    prio_reg[3][7:4] = PRIO3_TOP;
  end

  // read data is registered in the setup cycle, so every access has one wait-free access phase
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      prdata_q <= 32'h0000_0000;
    end else if (rd_en) begin
      unique case (apb_req.paddr)
        OFF_PRIO0:   prdata_q <= {24'h000000, prio_reg[0]};
        OFF_PRIO1:   prdata_q <= {24'h000000, prio_reg[1]};
        OFF_PRIO2:   prdata_q <= {24'h000000, prio_reg[2]};
        OFF_PRIO3:   prdata_q <= {24'h000000, prio_reg[3]};
        OFF_CC:      prdata_q <= {24'h000000, cpu_condition_priority};
        OFF_PENDING: prdata_q <= {18'h00000, pend_q};
        default:     prdata_q <= 32'h0000_0000;
      endcase
    end
  end

  assign apb_rsp = '{prdata:  prdata_q,
                     pready:  1'b1,
                     pslverr: apb_req.psel && apb_req.penable && !addr_ok};

  // current level
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cc_q <= CC_RESET;
    end else if (cpu_accept && svc_q.valid) begin
      cc_q <= svc_q.level;
    end else begin
      unique case (cpu_op)
        OP_EN:   cc_q <= LVL0;
        OP_DIS:  cc_q <= LVL3;
        OP_HALT: cc_q <= LVL0;
        OP_WFI:  cc_q <= LVL0;
        OP_POPCC: cc_q <= {stacked_cc[CC_HI_POS], stacked_cc[CC_LO_POS]};
        OP_RET:   cc_q <= {stacked_cc[CC_HI_POS], stacked_cc[CC_LO_POS]};
        OP_TRAP: cc_q <= LVL3;
        default: cc_q <= cc_q;
      endcase
    end
  end

  always_comb begin
    cpu_condition_priority            = 8'h00;
    cpu_condition_priority[CC_HI_POS] = cc_q[1];
    cpu_condition_priority[CC_LO_POS] = cc_q[0];
  end

  assign branch_if_masked   = (cc_q == LVL3);
  assign branch_if_unmasked = (cc_q != LVL3);

  // pending latches
  // shared vectors
  always_comb begin
    pend_set           = irq_req;
    pend_set[VEC_EXT0] = irq_req[VEC_EXT0] | ext_line_zero_req | auto_wake_from_halt_req;
    pend_set[VEC_EXT1] = irq_req[VEC_EXT1] | ext_line_one_req | aux_voltage_detector_req;
    pend_clr           = 14'h0000;
    if (cpu_accept && svc_q.valid) begin
      pend_clr[svc_q.vec] = 1'b1;
    end
  end

  // unserved stay latched; a new request beats the clear
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pend_q <= 14'h0000;
    end else begin
      pend_q <= (pend_q & ~pend_clr) | pend_set;
    end
  end

  // the voltage detector shares vector 3 but must not wake, so it is remembered apart
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      no_wake_q <= 1'b0;
    end else if (ext_line_one_req || irq_req[VEC_EXT1]) begin
      no_wake_q <= 1'b0;
    end else if (aux_voltage_detector_req) begin
      no_wake_q <= 1'b1;
    end
  end

  // halt and wake
  logic [13:0] wake_src;
  logic        can_sc_q;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      can_sc_q <= 1'b0;
    end else if (pend_clr[VEC_CANTX]) begin
      can_sc_q <= can_status_change;
    end else if (can_status_change) begin
      can_sc_q <= 1'b1;
    end
  end

  always_comb begin
    // fixed wake set; vectors 6 and 9 to 12 excluded
    wake_src = pend_q & irq_enable & WAKE_CAP;
    wake_src[VEC_CLOCK] = pend_q[VEC_CLOCK] && irq_enable[VEC_CLOCK] && active_halt_sel;
    wake_src[VEC_EXT1]  = pend_q[VEC_EXT1] && irq_enable[VEC_EXT1] && !no_wake_q;
    wake_src[VEC_CANTX] = pend_q[VEC_CANTX] && irq_enable[VEC_CANTX] && can_sc_q;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      halted <= 1'b0;
    end else if (halted && wake_src != 14'h0000) begin
      halted <= 1'b0;
    end else if (cpu_op == OP_HALT) begin
      halted <= 1'b1;
    end
  end

  assign wake = halted && (wake_src != 14'h0000);

  // first service after halt must come from a waking source
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      restrict_q <= 1'b0;
    end else if (wake) begin
      restrict_q <= 1'b1;
    end else if (cpu_accept && svc_q.valid) begin
      restrict_q <= 1'b0;
    end
  end

  // arbitration
  svc_t        win;
  logic [2:0]  win_rank;
  logic [13:0] cand;
  logic [2:0]  r;
  always_comb begin
    win      = '0;
    win_rank = 3'h0;
    r        = 3'h0;
    cand = pend_q & irq_enable;
    if (restrict_q || halted) begin
      cand = wake_src;
    end
    // walk from lowest order up so the lower number wins a tie
    for (int v = NUM_VEC - 1; v >= 0; v--) begin
      // top-level pair ignored; it outranks level 3
      r = (v == 0) ? 3'h4 : rank_of(prio_q[v]);
      // above current; re-entry follows from this
      if (cand[v] && (r > rank_of(cc_q)) && (r >= win_rank || !win.valid)) begin
        win.valid = 1'b1;
        win.vec   = 4'(v);
        win.level = (v == 0) ? LVL3 : prio_q[v];
        win.addr  = ADDR_VEC0 - 16'(2 * v);
        win_rank  = r;
      end
    end
  end

  // registered so the core sees a stable vector at the instruction boundary
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      svc_q <= '0;
    end else if (cpu_accept && svc_q.valid) begin
      svc_q <= '0;
    end else begin
      svc_q <= win;
    end
  end

  assign svc = svc_q;

  // pair of the entered vector, taken apart from svc_q so the entry check is independent
  logic [1:0] entry_lvl_q;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      entry_lvl_q <= CC_RESET;
    end else begin
      entry_lvl_q <= prio_q[svc_q.vec];
    end
  end

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  a_level0_write_kept: assert property (
    wr_en && apb_req.paddr == OFF_PRIO0 && apb_req.pwdata[5:4] == LVL0
    |=> prio_q[2] == $past(prio_q[2])) else $error("level 0 pair write was stored");

  a_enable_loads_zero: assert property (
    cpu_op == OP_EN && !(cpu_accept && svc_q.valid) |=> cc_q == LVL0 && !branch_if_masked)
    else $error("enable did not give level 0");

  a_disable_loads_three: assert property (
    cpu_op == OP_DIS && !(cpu_accept && svc_q.valid) |=> branch_if_masked)
    else $error("disable did not give level 3");

  a_trap_sets_three: assert property (
    cpu_op == OP_TRAP && !(cpu_accept && svc_q.valid) |=> cpu_condition_priority == 8'h28)
    else $error("trap did not set both bits");

  a_entry_loads_level: assert property (
    cpu_accept && svc_q.valid && svc_q.vec != VEC_TOP
    |=> cc_q == entry_lvl_q) else $error("entry level wrong");

  a_top_entry_three: assert property (
    cpu_accept && svc_q.valid && svc_q.vec == VEC_TOP |=> cc_q == LVL3)
    else $error("top-level entry not at level 3");

  a_prio3_nibble_ones: assert property (
    rd_en && apb_req.paddr == OFF_PRIO3 |=> apb_rsp.prdata[7:4] == PRIO3_TOP)
    else $error("upper nibble of fourth register not ones");

  a_served_above_level: assert property (
    svc_q.valid && svc_q.vec != VEC_TOP
    |-> rank_of(svc_q.level) > rank_of($past(cc_q))) else $error("served at or below level");

  a_pop_restores: assert property (
    cpu_op == OP_POPCC && !(cpu_accept && svc_q.valid)
    |=> cc_q[1] == $past(stacked_cc[CC_HI_POS]) && cc_q[0] == $past(stacked_cc[CC_LO_POS]))
    else $error("pop did not restore bits");

  a_clock_full_halt: assert property (
    halted && !active_halt_sel && !(pend_q[VEC_EXT1] && !no_wake_q)
    && (pend_q & irq_enable & (WAKE_CAP | 14'h0080) & 14'h3FF7) == 14'h0000 |-> !wake)
    else $error("clock time base woke full halt");

  a_vector_address: assert property (
    svc_q.valid |-> svc_q.addr == ADDR_VEC0 - {11'h000, svc_q.vec, 1'b0})
    else $error("vector address wrong");

  a_halt_wait_zero: assert property (
    (cpu_op == OP_HALT || cpu_op == OP_WFI) && !(cpu_accept && svc_q.valid) |=> cc_q == LVL0)
    else $error("halt or wait did not give level 0");

  a_branch_flags_match: assert property (
    branch_if_masked == (cpu_condition_priority == 8'h28) && branch_if_unmasked == !branch_if_masked)
    else $error("branch flags disagree with level bits");

  a_top_breaks_mask: assert property (
    cc_q == LVL3 && pend_q[VEC_TOP] && irq_enable[VEC_TOP] && !svc_q.valid
    |=> svc_q.valid && svc_q.vec == VEC_TOP) else $error("top-level blocked at level 3");

  a_level3_blocks: assert property (
    cc_q == LVL3 |=> !svc_q.valid || svc_q.vec == VEC_TOP)
    else $error("maskable vector offered at level 3");

  a_pending_kept: assert property (
    pend_q[9] && !(cpu_accept && svc_q.valid && svc_q.vec == 4'h9) |=> pend_q[9])
    else $error("unserved request lost");
endmodule : nested_interrupt_priority
`default_nettype wire

// [verilog/nest_prio_pkg.sv]
// shared constants and types for the nested interrupt priority block
package nest_prio_pkg;
  localparam int unsigned NUM_VEC = 14;
  localparam logic [7:0] OFF_PRIO0   = 8'h00;
  localparam logic [7:0] OFF_PRIO1   = 8'h04;
  localparam logic [7:0] OFF_PRIO2   = 8'h08;
  localparam logic [7:0] OFF_PRIO3   = 8'h0C;
  localparam logic [7:0] OFF_CC      = 8'h10;
  localparam logic [7:0] OFF_PENDING = 8'h14;
  localparam int unsigned CC_HI_POS  = 5;
  localparam int unsigned CC_LO_POS  = 3;
  // priority pair patterns {high, low}
  localparam logic [1:0] LVL0 = 2'h2;
  localparam logic [1:0] LVL1 = 2'h1;
  localparam logic [1:0] LVL2 = 2'h0;
  localparam logic [1:0] LVL3 = 2'h3;
  localparam logic [1:0] CC_RESET   = 2'h3;
  localparam logic [7:0] PRIO_RESET = 8'hFF;
  localparam logic [3:0] PRIO3_TOP  = 4'hF;
  localparam logic [3:0] VEC_TOP    = 4'h0;
  localparam logic [3:0] VEC_CLOCK  = 4'h1;
  localparam logic [3:0] VEC_EXT0   = 4'h2;
  localparam logic [3:0] VEC_EXT1   = 4'h3;
  localparam logic [3:0] VEC_CANTX  = 4'h7;
  localparam logic [15:0] ADDR_RESET = 16'hFFFE;
  localparam logic [15:0] ADDR_TRAP  = 16'hFFFC;
  localparam logic [15:0] ADDR_VEC0  = 16'hFFFA;
  // wake from halt per vector; clock time base and can tx handled apart
  localparam logic [13:0] WAKE_CAP = 14'h213D;
  typedef enum logic [2:0] {
    OP_NONE = 3'h0, OP_EN = 3'h1, OP_DIS = 3'h2, OP_HALT = 3'h3,
    OP_WFI  = 3'h4, OP_POPCC = 3'h5, OP_RET = 3'h6, OP_TRAP = 3'h7
  } cpu_op_t;
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } apb_req_t;
  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } apb_rsp_t;
  typedef struct packed {
    logic        valid;
    logic [3:0]  vec;
    logic [1:0]  level;
    logic [15:0] addr;
  } svc_t;
endpackage : nest_prio_pkg

// [testbench/cpu_partner.sv]
// cpu core model: takes the offered service promptly or after a few cycles
`timescale 1ns/1ps
`default_nettype none
module cpu_partner (
  input  wire logic                clk,
  input  wire logic                rst_b,
  input  wire nest_prio_pkg::svc_t svc,
  input  wire logic                go,
  input  wire logic                slow,
  output var logic                 cpu_accept
);
  import nest_prio_pkg::*;
  logic [1:0] wait_q;
  // a slow core lets the offer stand three cycles, so svc must hold meanwhile
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cpu_accept <= 1'h0;
      wait_q     <= 2'h0;
    end else begin
      cpu_accept <= 1'h0;
      if (go && svc.valid && !cpu_accept) begin
        if (!slow || wait_q == 2'h3) begin
          cpu_accept <= 1'h1;
          wait_q     <= 2'h0;
        end else begin
          wait_q <= wait_q + 2'h1;
        end
      end
    end
  end
endmodule : cpu_partner
`default_nettype wire

// [testbench/nested_interrupt_priority_tb_top.sv]
// self-checking bench for the nested interrupt priority block
`timescale 1ns/1ps
`default_nettype none
module nested_interrupt_priority_tb_top;
  import nest_prio_pkg::*;
  logic        clk = 1'h0;
  logic        rst_b = 1'h0;
  apb_req_t    req = '0;
  apb_rsp_t    rsp;
  cpu_op_t     cpu_op = OP_NONE;
  logic [7:0]  stacked_cc = 8'h00;
  logic        cpu_accept;
  logic [13:0] irq_req = 14'h0000;
  logic        aw_req = 1'h0;
  logic        ahs = 1'h0;
  logic        aux_voltage_detector = 1'h0;
  logic [13:0] ien = 14'h3FFF;
  logic        go = 1'h0;
  logic        slow = 1'h0;
  svc_t        svc;
  logic [7:0]  lvl_bits;
  logic        masked;
  logic        unmasked;
  logic        halted;
  logic        wake;
  int          fails = 0;
  int          compares = 0;
  int          cyc = 0;
  always #12.5 clk = ~clk;
  nested_interrupt_priority i_nested_interrupt_priority (
    .clk(clk), .rst_b(rst_b), .apb_req(req), .apb_rsp(rsp), .cpu_op(cpu_op),
    .stacked_cc(stacked_cc), .cpu_accept(cpu_accept), .irq_req(irq_req),
    .ext_line_zero_req(1'h0), .auto_wake_from_halt_req(aw_req), .ext_line_one_req(1'h0),
    .aux_voltage_detector_req(aux_voltage_detector), .can_status_change(1'h0), .irq_enable(ien),
    .active_halt_sel(ahs), .svc(svc), .cpu_condition_priority(lvl_bits),
    .branch_if_masked(masked), .branch_if_unmasked(unmasked), .halted(halted), .wake(wake));
  cpu_partner i_cpu_partner (
    .clk(clk), .rst_b(rst_b), .svc(svc), .go(go), .slow(slow), .cpu_accept(cpu_accept));
  task automatic stop_test();
    if (fails == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : stop_test
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // apb master; holds the request until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge clk);
    req <= '{psel: 1'h1, penable: 1'h0, pwrite: w, paddr: a, pwdata: d};
    @(posedge clk);
    req.penable <= 1'h1;
    do @(posedge clk); while (rsp.pready !== 1'h1);
    r = rsp.prdata;
    e = rsp.pslverr;
    req <= '0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'h1, a, d, r, e);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic exp_err);
    logic [31:0] r;
    logic        e;
    apb(1'h0, a, 32'h0, r, e);
    chk("prdata", exp, r);
    chk("pslverr", 32'(exp_err), 32'(e));
  endtask : rd
  task automatic op(input cpu_op_t o, input logic [7:0] s, input logic [7:0] exp);
    @(posedge clk);
    cpu_op <= o;
    stacked_cc <= s;
    @(posedge clk);
    cpu_op <= OP_NONE;
    @(negedge clk);
    chk("level_bits", 32'(exp), 32'(lvl_bits));
  endtask : op
  task automatic irq(input logic [13:0] m);
    @(posedge clk);
    irq_req <= m;
    @(posedge clk);
    irq_req <= 14'h0000;
  endtask : irq
  task automatic serve(input logic [3:0] v, input logic [1:0] l);
    int n;
    n = 0;
    while (svc.valid !== 1'h1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    chk("svc_valid", 32'h1, 32'(svc.valid));
    chk("svc_vec", 32'(v), 32'(svc.vec));
    chk("svc_level", 32'(l), 32'(svc.level));
    chk("svc_addr", 32'(ADDR_VEC0 - 16'(v) * 16'h2), 32'(svc.addr));
    @(posedge clk);
    go <= 1'h1;
    slow <= ~slow;
    do @(posedge clk); while (cpu_accept !== 1'h1);
    go <= 1'h0;
    @(negedge clk);
    chk("level_bits", 32'({l[1], 1'h0, l[0], 3'h0}), 32'(lvl_bits));
  endtask : serve
  // hang guard, well above the few hundred cycles the sequence needs
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails = fails + 1;
      stop_test();
    end
  end
  initial begin
    repeat (6) @(posedge clk);
    rst_b <= 1'h1;
    for (int i = 0; i < 4; i++) rd(OFF_PRIO0 + 8'(4 * i), 32'hFF, 1'h0);
    rd(OFF_CC, 32'h28, 1'h0);
    chk("masked", 32'h1, 32'(masked));
    rd(8'h20, 32'h0, 1'h1);
    wr(OFF_PRIO0, 32'hCF);
    wr(OFF_PRIO0, 32'h64);
    rd(OFF_PRIO0, 32'h44, 1'h0);
    wr(OFF_PRIO3, 32'h00);
    rd(OFF_PRIO3, 32'hF0, 1'h0);
    irq(14'h0001);
    serve(4'h0, LVL3);
    op(OP_EN, 8'h00, 8'h20);
    chk("unmasked", 32'h1, 32'(unmasked));
    wr(OFF_PRIO1, 32'hF5);
    irq(14'h0030);
    serve(4'h4, LVL1);
    repeat (4) @(negedge clk);
    chk("svc_valid", 32'h0, 32'(svc.valid));
    op(OP_RET, 8'h20, 8'h20);
    serve(4'h5, LVL1);
    irq(14'h0020);
    wr(OFF_PRIO1, 32'hF1);
    serve(4'h5, LVL2);
    op(OP_POPCC, 8'h28, 8'h28);
    op(OP_WFI, 8'h00, 8'h20);
    wr(OFF_PRIO3, 32'h01);
    irq(14'h3000);
    serve(4'hD, LVL2);
    op(OP_RET, 8'h20, 8'h20);
    serve(4'hC, LVL1);
    @(posedge clk);
    aw_req <= 1'h1;
    @(posedge clk);
    aw_req <= 1'h0;
    serve(4'h2, LVL2);
    op(OP_HALT, 8'h00, 8'h20);
    chk("halted", 32'h1, 32'(halted));
    // the voltage detector alone shares vector 3 but must not wake
    @(posedge clk);
    aux_voltage_detector <= 1'h1;
    @(posedge clk);
    aux_voltage_detector <= 1'h0;
    irq(14'h0200);
    irq(14'h0002);
    @(negedge clk);
    chk("wake", 32'h0, 32'(wake));
    @(posedge clk);
    ahs <= 1'h1;
    @(negedge clk);
    chk("wake", 32'h1, 32'(wake));
    serve(4'h1, LVL1);
    @(posedge clk);
    ahs <= 1'h0;
    chk("halted", 32'h0, 32'(halted));
    serve(4'h9, LVL3);
    op(OP_EN, 8'h00, 8'h20);
    serve(4'h3, LVL1);
    @(posedge clk);
    ien <= 14'h3EFF;
    irq(14'h0100);
    repeat (4) @(negedge clk);
    chk("svc_valid", 32'h0, 32'(svc.valid));
    @(posedge clk);
    ien <= 14'h3FFF;
    serve(4'h8, LVL3);
    op(OP_EN, 8'h00, 8'h20);
    op(OP_DIS, 8'h00, 8'h28);
    chk("masked", 32'h1, 32'(masked));
    op(OP_EN, 8'h00, 8'h20);
    op(OP_TRAP, 8'h00, 8'h28);
    stop_test();
  end
endmodule : nested_interrupt_priority_tb_top
`default_nettype wire
